// ===== hw/spc_pkg.sv
package spc_pkg;
  // Command codes
  localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
  localparam logic [7:0] OP_STATUS_RD  = 8'h05;
  localparam logic [7:0] OP_DYN_RD     = 8'hfa;
  localparam logic [7:0] OP_DYN_RD4    = 8'he0;
  localparam logic [7:0] OP_DYN_WR     = 8'hfb;
  localparam logic [7:0] OP_DYN_WR4    = 8'he1;
  localparam logic [7:0] OP_PERS_RD    = 8'hfc;
  localparam logic [7:0] OP_PERS_RD4   = 8'he2;
  localparam logic [7:0] OP_PERS_PGM   = 8'hfd;
  localparam logic [7:0] OP_PERS_PGM4  = 8'he3;
  localparam logic [7:0] OP_PERS_ERASE = 8'he4;
  localparam logic [7:0] OP_CFG_RD     = 8'h2b;
  localparam logic [7:0] OP_CFG_PGM    = 8'h2f;
  localparam logic [7:0] OP_LOCK_RD    = 8'ha7;
  localparam logic [7:0] OP_LOCK_CLR   = 8'ha6;

  // Field lengths in serial bits
  localparam logic [6:0] OPC_BITS   = 7'h08;
  localparam logic [6:0] ADDR3_BITS = 7'h18;
  localparam logic [6:0] ADDR4_BITS = 7'h20;
  localparam logic [6:0] BYTE_BITS  = 7'h08;
  localparam logic [6:0] WORD_BITS  = 7'h10;
  localparam logic [6:0] NO_BITS    = 7'h00;
  localparam logic [6:0] BITCNT_MAX = 7'h7f;

  // Register values and bit positions
  localparam logic [7:0]  GUARD_OPEN    = 8'hff;
  localparam logic [7:0]  GUARD_SHUT    = 8'h00;
  localparam logic [15:0] CFG_RESET     = 16'hffff;
  localparam logic [7:0]  LOCK_RESET    = 8'h01;
  localparam int          LOCK_FLAG_BIT = 0;
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_WEL_BIT    = 1;
  localparam int          EXT_ADDR_BIT  = 7;

  // Controller register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam int         CTRL_EXT_BIT  = 8;
  localparam int         CTRL_POLL_BIT = 9;

  // Address length of a command
  function automatic logic [6:0] addrBits(input logic [7:0] op,
                                          input logic       ext);
    case (op)
      OP_DYN_RD, OP_DYN_WR, OP_PERS_RD, OP_PERS_PGM:
        addrBits = ext ? ADDR4_BITS : ADDR3_BITS;
      OP_DYN_RD4, OP_DYN_WR4, OP_PERS_RD4, OP_PERS_PGM4:
        addrBits = ADDR4_BITS;
      default: addrBits = NO_BITS;
    endcase
  endfunction

  // Write data length of a command
  function automatic logic [6:0] wrBits(input logic [7:0] op);
    case (op)
      OP_DYN_WR, OP_DYN_WR4: wrBits = BYTE_BITS;
      OP_CFG_PGM:            wrBits = WORD_BITS;
      default:               wrBits = NO_BITS;
    endcase
  endfunction

  // Read data length of one repeat of a command
  function automatic logic [6:0] rdBits(input logic [7:0] op);
    case (op)
      OP_DYN_RD, OP_DYN_RD4, OP_PERS_RD, OP_PERS_RD4,
      OP_LOCK_RD, OP_STATUS_RD: rdBits = BYTE_BITS;
      OP_CFG_RD:                rdBits = WORD_BITS;
      default:                  rdBits = NO_BITS;
    endcase
  endfunction

  // Commands that need the write enable latch
  function automatic logic needsWel(input logic [7:0] op);
    case (op)
      OP_PERS_PGM, OP_PERS_PGM4, OP_PERS_ERASE, OP_CFG_PGM,
      OP_LOCK_CLR: needsWel = 1'b1;
      default:     needsWel = 1'b0;
    endcase
  endfunction
endpackage

// ===== hw/spc_link.sv
`timescale 1ns/1ps
interface spc_link;
  logic csN;
  logic sclk;
  logic mosi;
  logic miso;
  logic misoOe;

  modport flash (
    input  csN,
    input  sclk,
    input  mosi,
    output miso,
    output misoOe
  );

  modport host (
    output csN,
    output sclk,
    output mosi,
    input  miso,
    input  misoOe
  );
endinterface

// ===== hw/spc_flash_end.sv
`timescale 1ns/1ps
//
// Contract
// - Selectable reads 3/4-byte address, alternates always 4
// - Dynamic value out on falling edges, repeats
// - Guard bytes only 00h protected, FFh open
// - Dynamic writes need no write enable
// - Dynamic write: opcode, address, byte; CS starts
// - Persistent reads single-line only, on serial out
// - Persistent read repeats same byte every 8
// - Persistent program: enabled, opcode plus address only
// - Busy during persistent program, then latch clears
// - Persistent erase sets all bits, exact CS
// - Busy during erase, suspend refused, latch clears
// - Config read low byte first, repeats 16
// - Config program two bytes, exact CS rise
// - Busy during config program, then latch clears
// - Lock read single-line only, idle only
// - Host polls busy before next command
// - Lock clear enabled, exact CS, clears flag
// - Busy during lock clear, then latch clears
// - Status read still answered while busy
// - Host sends first address of sector
// - Extended addressing flag is bank bit 7
// - Write enable command sets the latch
module spc_flash_end
  import spc_pkg::*;
#(
  parameter int SEC_W       = 4,
  parameter int SEC_LSB     = 16,
  parameter int PROG_CYCLES = 200
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  spc_link.flash           link,
  input  wire logic        quadMode,
  input  wire logic [7:0]  bankReg,
  output logic             busyFlag,
  output logic             welFlag,
  output logic             lockFlag,
  output logic [15:0]      configOut
);
  localparam int NUM_SEC = 1 << SEC_W;

  typedef enum logic [2:0] {
    PH_OPC, PH_ADDR, PH_DATA, PH_OUT, PH_SKIP
  } spc_phase_e;

  spc_phase_e        phase;
  spc_phase_e        next_phase;
  logic [2:0]        syncA;
  logic [2:0]        syncB;
  logic              sclkOld;
  logic              csOld;
  logic [6:0]        bitCnt;
  logic [31:0]       inSh;
  logic [7:0]        opcode;
  logic [31:0]       addr;
  logic [15:0]       outSh;
  logic              misoQ;
  logic              busy;
  logic              write_enable_latch;
  logic [15:0]       timer;
  logic [7:0]        pendOp;
  logic [SEC_W-1:0]  pendSec;
  logic [15:0]       pendCfg;
  logic [15:0]       cfg;
  logic [7:0]        lockReg;
  logic [7:0]        dynGuard [NUM_SEC];
  logic [7:0]        persGuard [NUM_SEC];

  // Pin samples after two flops
  wire sclkS = syncB[2];
  wire csS   = syncB[1];
  wire mosiS = syncB[0];
  wire rise  = clkEn & sclkS & ~sclkOld & ~csS;
  wire fall  = clkEn & ~sclkS & sclkOld & ~csS;
  wire csRise = clkEn & csS & ~csOld;

  // Frame decode; opcode is taken live while it is still arriving
  wire [31:0] next_inSh = {inSh[30:0], mosiS};
  wire [6:0]  next_bitCnt = (bitCnt == BITCNT_MAX) ? bitCnt
                            : bitCnt + 7'h01;
  wire [7:0]  opNow = (phase == PH_OPC) ? next_inSh[7:0] : opcode;
  wire        extAddr = bankReg[EXT_ADDR_BIT];
  wire [6:0]  aBits = addrBits(opNow, extAddr);
  wire [6:0]  hdrBits = OPC_BITS + aBits;
  wire [6:0]  allBits = hdrBits + wrBits(opNow);
  wire        atOpc = (phase == PH_OPC) && (next_bitCnt == OPC_BITS);
  wire        atHdr = (phase == PH_ADDR) && (next_bitCnt == hdrBits);
  wire        goAddr = aBits != NO_BITS;
  wire        goData = wrBits(opNow) != NO_BITS;
  wire        goOut = rdBits(opNow) != NO_BITS;
  wire        singleOnly = (opNow == OP_PERS_RD) ||
                           (opNow == OP_PERS_RD4) ||
                           (opNow == OP_LOCK_RD);
  // While busy only the status read is served
  wire        blocked = (busy && opNow != OP_STATUS_RD) ||
                        (quadMode && singleOnly);

  // Sector picked from the upper address; low bits are not decoded
  wire [SEC_W-1:0] secNow = next_inSh[SEC_LSB +: SEC_W];
  wire [SEC_W-1:0] secAddr = addr[SEC_LSB +: SEC_W];
  wire [7:0]       stByte = 8'(({1'b0, write_enable_latch, busy}) <<
                                  ST_BUSY_BIT);
  wire [7:0]       dynNow = dynGuard[secNow];
  wire [7:0]       persNow = persGuard[secNow];

  // Read word, rotated so each repeat gives the same bits
  logic [15:0] rdWord;
  always_comb begin
    case (opNow)
      OP_DYN_RD, OP_DYN_RD4:   rdWord = {dynNow, dynNow};
      OP_PERS_RD, OP_PERS_RD4: rdWord = {persNow, persNow};
      OP_CFG_RD:               rdWord = {cfg[7:0], cfg[15:8]};
      OP_LOCK_RD:              rdWord = {lockReg, lockReg};
      OP_STATUS_RD:            rdWord = {stByte, stByte};
      default:                 rdWord = 16'h0000;
    endcase
  end

  // Phase sequencing of one frame
  always_comb begin
    next_phase = phase;
    case (phase)
      PH_OPC: begin
        if (atOpc) begin
          if (blocked)
            next_phase = PH_SKIP;
          else if (goAddr)
            next_phase = PH_ADDR;
          else if (goData)
            next_phase = PH_DATA;
          else if (goOut)
            next_phase = PH_OUT;
          else
            next_phase = PH_SKIP;
        end
      end
      PH_ADDR: begin
        if (atHdr)
          next_phase = goData ? PH_DATA : goOut ? PH_OUT : PH_SKIP;
      end
      PH_DATA: begin
        if (next_bitCnt == allBits)
          next_phase = PH_SKIP;
      end
      default: next_phase = phase;
    endcase
  end

  // Execution is taken only when CS rises on the exact last bit
  wire execOk = csRise && (phase != PH_OPC) && (bitCnt == allBits) &&
                !busy;
  wire doWren = execOk && (opcode == OP_WR_ENABLE);
  wire doDyn = execOk && (opcode == OP_DYN_WR || opcode == OP_DYN_WR4);
  wire doStart = execOk && needsWel(opcode) && write_enable_latch;
  wire busyDone = busy && (timer == 16'h0000);

  // Pin synchronisers; also frozen by the clock enable
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= 3'h2;
      syncB <= 3'h2;
      sclkOld <= 1'b0;
      csOld <= 1'b1;
    end else if (clkEn) begin
      syncA <= {link.sclk, link.csN, link.mosi};
      syncB <= syncA;
      sclkOld <= sclkS;
      csOld <= csS;
    end
  end

  // Shift-in engine, samples on SCLK rising edges
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_OPC;
      bitCnt <= NO_BITS;
      inSh <= 32'h0;
      opcode <= 8'h00;
      addr <= 32'h0;
    end else if (clkEn && csS) begin
      phase <= PH_OPC;
      bitCnt <= NO_BITS;
    end else if (rise) begin
      inSh <= next_inSh;
      bitCnt <= next_bitCnt;
      phase <= next_phase;
      if (atOpc)
        opcode <= next_inSh[7:0];
      if (atHdr)
        addr <= next_inSh;
    end
  end

  // Shift-out on falling edges, address never advances
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      outSh <= 16'h0000;
      misoQ <= 1'b0;
    end else if (clkEn && csS) begin
      misoQ <= 1'b0;
    end else if (rise && next_phase == PH_OUT && phase != PH_OUT) begin
      outSh <= rdWord;
    end else if (fall && phase == PH_OUT) begin
      misoQ <= outSh[15];
      outSh <= {outSh[14:0], outSh[15]};
    end
  end

  // Latch, busy flag and program timer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_enable_latch <= 1'b0;
      busy <= 1'b0;
      timer <= 16'h0000;
      pendOp <= 8'h00;
      pendSec <= '0;
      pendCfg <= 16'h0000;
    end else if (clkEn) begin
      if (doWren)
        write_enable_latch <= 1'b1;
      if (doStart) begin
        busy <= 1'b1;
        timer <= 16'(PROG_CYCLES - 1);
        pendOp <= opcode;
        pendSec <= secAddr;
        pendCfg <= {inSh[7:0], inSh[15:8]};
      end else if (busyDone) begin
        busy <= 1'b0;
        write_enable_latch <= 1'b0;
      end else if (busy) begin
        timer <= timer - 16'h0001;
      end
    end
  end

  // Config and lock registers change at completion
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= CFG_RESET;
      lockReg <= LOCK_RESET;
    end else if (clkEn && busyDone) begin
      if (pendOp == OP_CFG_PGM)
        cfg <= pendCfg;
      if (pendOp == OP_LOCK_CLR)
        lockReg[LOCK_FLAG_BIT] <= 1'b0;
    end
  end

  // Guard arrays; dynamic writes act at once, no latch needed
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_SEC; i++) begin
        dynGuard[i] <= GUARD_OPEN;
        persGuard[i] <= GUARD_OPEN;
      end
    end else if (clkEn) begin
      if (doDyn)
        dynGuard[secAddr] <= inSh[7:0];
      if (busyDone && (pendOp == OP_PERS_PGM || pendOp == OP_PERS_PGM4))
        persGuard[pendSec] <= GUARD_SHUT;
      if (busyDone && pendOp == OP_PERS_ERASE) begin
        for (int i = 0; i < NUM_SEC; i++)
          persGuard[i] <= GUARD_OPEN;
      end
    end
  end

  // Outputs; erase suspend is just another command refused while busy
  assign link.miso = misoQ;
  assign link.misoOe = (phase == PH_OUT) && !csS;
  assign busyFlag = busy;
  assign welFlag = write_enable_latch;
  assign lockFlag = lockReg[LOCK_FLAG_BIT];
  assign configOut = cfg;
endmodule

// ===== hw/spc_host_end.sv
`timescale 1ns/1ps
module spc_host_end
  import spc_pkg::*;
#(
  parameter int SCLK_HALF = 8
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        clkEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdData,
  spc_link.host            link
);
  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_GAP} spc_hstate_e;

  spc_hstate_e  state;
  logic [7:0]   ctrlOp;
  logic         ctrlExt;
  logic         ctrlPoll;
  logic [31:0]  addrReg;
  logic [15:0]  wdataReg;
  logic [15:0]  rdataReg;
  logic         done;
  logic         inPoll;
  logic [7:0]   curOp;
  logic [55:0]  txSh;
  logic [15:0]  rxSh;
  logic [6:0]   bitNo;
  logic [7:0]   divCnt;
  logic         misoA;
  logic         misoB;
  logic         csQ;
  logic         sclkQ;
  logic         mosiQ;

  // Serial image: opcode, address, data low byte first
  function automatic logic [55:0] buildTx(input logic [7:0]  op,
                                          input logic        ext,
                                          input logic [31:0] a,
                                          input logic [15:0] w);
    logic [6:0]  ab;
    logic [55:0] head;
    ab = addrBits(op, ext);
    if (ab == ADDR4_BITS)
      head = {op, a, 16'h0000};
    else if (ab == ADDR3_BITS)
      head = {op, a[23:0], 24'h000000};
    else
      head = {op, 48'h0};
    buildTx = head | ({w[7:0], w[15:8], 40'h0} >> (OPC_BITS + ab));
  endfunction

  wire [6:0] curA = addrBits(curOp, ctrlExt);
  wire [6:0] rdStart = OPC_BITS + curA + wrBits(curOp);
  wire [6:0] total = rdStart + rdBits(curOp);
  wire       halfUp = divCnt == 8'(SCLK_HALF - 1);
  wire       ctrlWr = regWr && regAddr == REG_CTRL;
  wire       active = state != H_IDLE;
  wire       lastBit = bitNo + 7'h01 == total;
  wire       devBusy = rxSh[ST_BUSY_BIT];
  // Status poll after a write-type frame, and again while busy
  wire       pollNext = inPoll ? devBusy
                       : ctrlPoll && (needsWel(curOp) ||
                         wrBits(curOp) == BYTE_BITS);

  // Register write side; a start is ignored while a frame runs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlOp <= 8'h00;
      ctrlExt <= 1'b0;
      ctrlPoll <= 1'b0;
      addrReg <= 32'h0;
      wdataReg <= 16'h0000;
    end else if (clkEn && regWr && !active) begin
      if (regAddr == REG_CTRL) begin
        ctrlOp <= regWrData[7:0];
        ctrlExt <= regWrData[CTRL_EXT_BIT];
        ctrlPoll <= regWrData[CTRL_POLL_BIT];
      end
      if (regAddr == REG_ADDR)
        addrReg <= regWrData;
      if (regAddr == REG_WDATA)
        wdataReg <= regWrData[15:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  wire [31:0] rdMux = (regAddr == REG_CTRL)   ? {22'h0, ctrlPoll,
                                                 ctrlExt, ctrlOp} :
                      (regAddr == REG_ADDR)   ? addrReg :
                      (regAddr == REG_WDATA)  ? {16'h0, wdataReg} :
                      (regAddr == REG_STATUS) ? {30'h0, done, active} :
                      (regAddr == REG_RDATA)  ? {16'h0, rdataReg} :
                      32'h0;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      regRdData <= 32'h0;
    else if (clkEn)
      regRdData <= regRd ? rdMux : 32'h0;
  end

  // Incoming serial data passes two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      misoA <= 1'b0;
      misoB <= 1'b0;
    end else if (clkEn) begin
      misoA <= link.miso;
      misoB <= misoA;
    end
  end

  // Mode 0 frame engine; SCLK is a divided core clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= H_IDLE;
      csQ <= 1'b1;
      sclkQ <= 1'b0;
      mosiQ <= 1'b0;
      done <= 1'b0;
      inPoll <= 1'b0;
      curOp <= 8'h00;
      txSh <= 56'h0;
      rxSh <= 16'h0000;
      bitNo <= NO_BITS;
      divCnt <= 8'h00;
      rdataReg <= 16'h0000;
    end else if (clkEn) begin
      divCnt <= (halfUp || !active) ? 8'h00 : divCnt + 8'h01;
      case (state)
        H_IDLE: begin
          if (ctrlWr) begin
            curOp <= regWrData[7:0];
            txSh <= buildTx(regWrData[7:0], regWrData[CTRL_EXT_BIT],
                            addrReg, wdataReg);
            mosiQ <= regWrData[7];
            csQ <= 1'b0;
            bitNo <= NO_BITS;
            inPoll <= 1'b0;
            done <= 1'b0;
            state <= H_LOW;
          end
        end
        H_LOW: begin
          if (halfUp) begin
            sclkQ <= 1'b1;
            if (bitNo >= rdStart)
              rxSh <= {rxSh[14:0], misoB};
            state <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (halfUp) begin
            sclkQ <= 1'b0;
            bitNo <= bitNo + 7'h01;
            txSh <= {txSh[54:0], 1'b0};
            mosiQ <= txSh[54];
            csQ <= lastBit;
            state <= lastBit ? H_GAP : H_LOW;
          end
        end
        default: begin
          if (halfUp) begin
            if (!inPoll)
              rdataReg <= (rdBits(curOp) == WORD_BITS) ?
                          {rxSh[7:0], rxSh[15:8]} : {8'h00, rxSh[7:0]};
            if (pollNext) begin
              curOp <= OP_STATUS_RD;
              txSh <= buildTx(OP_STATUS_RD, 1'b0, 32'h0, 16'h0000);
              mosiQ <= OP_STATUS_RD[7];
              csQ <= 1'b0;
              bitNo <= NO_BITS;
              inPoll <= 1'b1;
              state <= H_LOW;
            end else begin
              done <= 1'b1;
              state <= H_IDLE;
            end
          end
        end
      endcase
    end
  end

  assign link.csN = csQ;
  assign link.sclk = sclkQ;
  assign link.mosi = mosiQ;
endmodule

// ===== verification/spc_link_assertions.sv
`timescale 1ns/1ps
module spc_link_assertions
  import spc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic csN,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  logic       sclkQ;
  logic       csnQ;
  logic [6:0] bitCnt;
  logic [7:0] opc;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Edge finder and bit counter; the count is kept after select rises,
  // since the flash sees that rise through its synchroniser, late
  wire sclkRise = sclk & ~sclkQ;
  wire csFall   = csnQ & ~csN;
  wire isAddrRd = (opc == OP_DYN_RD) || (opc == OP_DYN_RD4) ||
                  (opc == OP_PERS_RD) || (opc == OP_PERS_RD4);
  wire isRead   = isAddrRd || (opc == OP_CFG_RD) ||
                  (opc == OP_LOCK_RD) || (opc == OP_STATUS_RD);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclkQ  <= 1'b0;
      csnQ   <= 1'b1;
      bitCnt <= 7'h00;
      opc    <= 8'h00;
    end else begin
      sclkQ  <= sclk;
      csnQ   <= csN;
      bitCnt <= csFall ? 7'h00 :
                (!csN && sclkRise && bitCnt != BITCNT_MAX) ?
                bitCnt + 7'h01 : bitCnt;
      opc    <= (!csN && sclkRise && bitCnt < OPC_BITS) ?
                {opc[6:0], mosi} : opc;
    end
  end

  AST_IDLE_LOW: assert property (csN |-> !sclk)
    else $error("serial clock not low while deselected");
  AST_CS_ON_BYTE: assert property ($rose(csN) |->
    (bitCnt != 7'h00) && (bitCnt[2:0] == 3'h0))
    else $error("select released off a byte boundary");
  AST_OE_SELECTED: assert property (misoOe |-> !$past(csN, 2))
    else $error("serial out driven while deselected");
  AST_OE_READS: assert property (misoOe |-> isRead)
    else $error("serial out driven for a non-read command");
  AST_OE_AFTER_ADDR: assert property (
    misoOe && isAddrRd |-> bitCnt >= 7'h20)
    else $error("read data before the address ended");
  AST_OE_AFTER_OPC: assert property (misoOe |-> bitCnt >= OPC_BITS)
    else $error("read data before the opcode ended");
  AST_MISO_ON_FALL: assert property (
    !csN && !$past(csN) && $changed(miso) |-> !sclk)
    else $error("serial out moved while the clock was high");
  AST_MOSI_ON_FALL: assert property (
    !csN && !$past(csN) && $changed(mosi) |-> !sclk)
    else $error("serial in moved while the clock was high");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> sclk[*8])
    else $error("serial clock high phase too short");

  cover property ($rose(misoOe));
  cover property ($rose(csN) && bitCnt == 7'h30);
  cover property ($rose(csN) && opc == OP_CFG_PGM);
endmodule

// ===== verification/spc_bench.sv
`timescale 1ns/1ps
module spc_bench;
  import spc_pkg::*;
  localparam logic [31:0] S2 = 32'h0002_0000;
  localparam logic [31:0] S3 = 32'h0003_0000;
  localparam logic [31:0] S5 = 32'h0005_0000;
  logic        core_clk;
  logic        reset_n;
  logic        clkEn;
  logic [7:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdData;
  logic        quadMode;
  logic [7:0]  bankReg;
  logic        busyFlag;
  logic        welFlag;
  logic        lockFlag;
  logic [15:0] configOut;
  logic [31:0] rdVal;
  int          fails;
  int          checks;

  spc_link link ();

  spc_host_end #(.SCLK_HALF(8)) u_spc_host_end (
    .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .link(link));

  // Busy is still set when the first status poll reads it, so the host must poll again
  spc_flash_end #(.SEC_W(4), .SEC_LSB(16), .PROG_CYCLES(200)) u_spc_flash_end (
    .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .link(link),
    .quadMode(quadMode), .bankReg(bankReg), .busyFlag(busyFlag),
    .welFlag(welFlag), .lockFlag(lockFlag), .configOut(configOut));

  spc_link_assertions u_spc_link_assertions (
    .core_clk(core_clk), .reset_n(reset_n), .csN(link.csN),
    .sclk(link.sclk), .mosi(link.mosi), .miso(link.miso),
    .misoOe(link.misoOe));

  // Free-running 100 MHz clock
  always #5 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // One-cycle strobes launched just after an edge
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  // Whole frame with auto-poll; bounded waits only
  task automatic cmd(input logic [7:0] op, input logic ext,
                     input logic [31:0] a, input logic [15:0] w,
                     input logic busy);
    int n;
    regWrite(REG_ADDR, a);
    regWrite(REG_WDATA, {16'h0000, w});
    regWrite(REG_CTRL, {22'h0, 1'b1, ext, op});
    n = 0;
    while (busy && busyFlag !== 1'b1 && n < 5000) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (busy) chk("busyFlag", 32'h1, {31'h0, busyFlag});
    n = 0;
    do begin
      regRead(REG_STATUS, rdVal);
      n++;
    end while (rdVal[1:0] !== 2'b10 && n < 5000);
    if (n >= 5000) begin
      fails++;
      print_verdict();
    end
    if (busy) flagChk("busy after poll", 1'b0, busyFlag);
  endtask

  task automatic rdChk(input string what, input logic [7:0] op,
                       input logic ext, input logic [31:0] a,
                       input logic [31:0] exp);
    cmd(op, ext, a, 16'h0000, 1'b0);
    regRead(REG_RDATA, rdVal);
    chk(what, exp, rdVal);
  endtask

  task automatic flagChk(input string what, input logic exp,
                         input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask

  initial begin
    core_clk  = 1'b0;
    reset_n   = 1'b0;
    clkEn     = 1'b1;
    regAddr   = 8'h00;
    regWrData = 32'h0;
    regWr     = 1'b0;
    regRd     = 1'b0;
    quadMode  = 1'b0;
    bankReg   = 8'h00;
    fails     = 0;
    checks    = 0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1 flagChk("busyFlag", 1'b0, busyFlag);
    flagChk("welFlag", 1'b0, welFlag);
    flagChk("lockFlag", 1'b1, lockFlag);
    chk("configOut", 32'hffff, {16'h0, configOut});
    regRead(8'h20, rdVal);
    chk("unmapped", 32'h0, rdVal);
    // A start strobed while the clock enable is low must be lost
    @(posedge core_clk);
    clkEn <= 1'b0;
    regWrite(REG_CTRL, {24'h0, OP_WR_ENABLE});
    repeat (4) @(posedge core_clk);
    clkEn <= 1'b1;
    regRead(REG_STATUS, rdVal);
    chk("frozen status", 32'h0, rdVal);
    // Dynamic guards, 3- and 4-byte forms, no latch needed
    rdChk("dyn S3", OP_DYN_RD, 1'b0, S3, 32'hff);
    cmd(OP_DYN_WR, 1'b0, S3, 16'h0000, 1'b0);
    flagChk("welFlag", 1'b0, welFlag);
    rdChk("dyn4 S3", OP_DYN_RD4, 1'b0, S3, 32'h00);
    @(posedge core_clk);
    bankReg <= 8'h80;
    cmd(OP_DYN_WR4, 1'b1, S5, 16'h0000, 1'b0);
    rdChk("dyn ext S5", OP_DYN_RD, 1'b1, S5, 32'h00);
    cmd(OP_DYN_WR, 1'b1, S5, 16'h00ff, 1'b0);
    rdChk("dyn4 S5", OP_DYN_RD4, 1'b1, S5, 32'hff);
    @(posedge core_clk);
    bankReg <= 8'h00;
    // Persistent program refused, then enabled
    cmd(OP_PERS_PGM, 1'b0, S2, 16'h0000, 1'b0);
    rdChk("pers S2", OP_PERS_RD, 1'b0, S2, 32'hff);
    cmd(OP_WR_ENABLE, 1'b0, 32'h0, 16'h0000, 1'b0);
    flagChk("welFlag", 1'b1, welFlag);
    cmd(OP_PERS_PGM, 1'b0, S2, 16'h0000, 1'b1);
    flagChk("welFlag", 1'b0, welFlag);
    rdChk("pers4 S2", OP_PERS_RD4, 1'b0, S2, 32'h00);
    // Quad command mode refuses single-line reads
    @(posedge core_clk);
    quadMode <= 1'b1;
    rdChk("quad pers S3", OP_PERS_RD, 1'b0, S3, 32'h00);
    rdChk("quad lock", OP_LOCK_RD, 1'b0, 32'h0, 32'h00);
    @(posedge core_clk);
    quadMode <= 1'b0;
    // Bulk erase of persistent guards
    cmd(OP_WR_ENABLE, 1'b0, 32'h0, 16'h0000, 1'b0);
    cmd(OP_PERS_ERASE, 1'b0, 32'h0, 16'h0000, 1'b1);
    flagChk("welFlag", 1'b0, welFlag);
    rdChk("erased S2", OP_PERS_RD, 1'b0, S2, 32'hff);
    // Configuration program refused, then enabled, then read
    cmd(OP_CFG_PGM, 1'b0, 32'h0, 16'h1234, 1'b0);
    chk("configOut", 32'hffff, {16'h0, configOut});
    cmd(OP_WR_ENABLE, 1'b0, 32'h0, 16'h0000, 1'b0);
    cmd(OP_CFG_PGM, 1'b0, 32'h0, 16'h1234, 1'b1);
    chk("configOut", 32'h1234, {16'h0, configOut});
    flagChk("welFlag", 1'b0, welFlag);
    rdChk("config", OP_CFG_RD, 1'b0, 32'h0, 32'h1234);
    // Lock flag read and clear
    rdChk("lock", OP_LOCK_RD, 1'b0, 32'h0, 32'h01);
    cmd(OP_WR_ENABLE, 1'b0, 32'h0, 16'h0000, 1'b0);
    cmd(OP_LOCK_CLR, 1'b0, 32'h0, 16'h0000, 1'b1);
    flagChk("lockFlag", 1'b0, lockFlag);
    flagChk("welFlag", 1'b0, welFlag);
    rdChk("lock clr", OP_LOCK_RD, 1'b0, 32'h0, 32'h00);
    print_verdict();
  end
endmodule
